//--- src/synth_ctrl_pkg.sv
// Constants shared by the synthesizer control logic
package synth_ctrl_pkg;
  // Serial frame layout
  localparam int FRAME_BITS = 22;
  localparam int DATA_BITS = 18;
  localparam int ADDR_BITS = 4;
  // Register addresses
  localparam logic [3:0] ADDR_MAIN_CONFIGURATION = 4'h0;
  localparam logic [3:0] ADDR_SECTION_POWER_ENABLES = 4'h2;
  localparam logic [3:0] ADDR_RF_BAND1_DIVIDE_VALUE = 4'h3;
  localparam logic [3:0] ADDR_RF_BAND2_DIVIDE_VALUE = 4'h4;
  localparam logic [3:0] ADDR_IF_DIVIDE_VALUE = 4'h5;
  // Main configuration fields
  localparam int AUX_SEL_LSB = 12;
  localparam int IF_LOW_BIAS_BIT = 5;
  localparam int AUTO_POWER_ON_BIT = 3;
  localparam logic [1:0] AUX_SEL_LOW = 2'h1;
  localparam logic [1:0] AUX_SEL_LOCK = 2'h3;
  // Power enable fields
  localparam int IF_ENABLE_BIT = 1;
  localparam int RF_ENABLE_BIT = 0;
  // Divide value widths
  localparam int RF1_N_BITS = 18;
  localparam int RF2_N_BITS = 17;
  localparam int IF_N_BITS = 16;
  // Reset values of the register bank
  localparam logic [17:0] MAIN_CONFIGURATION_RST = 18'h00002;
  localparam logic [17:0] REG_ZERO_RST = 18'h00000;
  // Fixed reference division
  localparam int REF_DIVIDE_RATIO = 65;
  // Prescaler modulus (P / P+1)
  localparam int PRESCALER_P = 32;
  // Self tune: 6.5 periods counted in half periods
  localparam int TUNE_HALF_PERIODS = 13;
  // Settle: 28 periods counted in half periods
  localparam int SETTLE_HALF_PERIODS = 56;
endpackage : synth_ctrl_pkg

//--- src/pll_timing.sv
// Per-PLL self-tune and settle sequencer
`timescale 1ns/100ps
module pll_timing
  import synth_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic half_tick_i,
  input wire logic enable_i,
  input wire logic retune_i,
  output logic tuning_o,
  output logic settled_o
);
  import synth_ctrl_pkg::*;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_TUNE = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_LOCKED = 4'b1000
  } tstate_e;

  typedef struct packed {
    tstate_e st;
    logic [6:0] cnt;
  } state_s;

  state_s cur_ff, nxt_cur;

  // Sequencer: off, self-tune 6.5 periods, then settle 21.5 more periods, 28 in all
  always_comb begin
    nxt_cur = cur_ff;
    if (!enable_i) begin
      nxt_cur.st = ST_OFF;
      nxt_cur.cnt = 7'h00;
    end else if (retune_i || cur_ff.st == ST_OFF) begin
      nxt_cur.st = ST_TUNE;
      nxt_cur.cnt = 7'h00;
    end else if (half_tick_i) begin
      unique case (cur_ff.st)
        ST_TUNE: begin
          nxt_cur.cnt = cur_ff.cnt + 7'h01;
          if (cur_ff.cnt == 7'(TUNE_HALF_PERIODS - 1)) begin
            nxt_cur.st = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          nxt_cur.cnt = cur_ff.cnt + 7'h01;
          if (cur_ff.cnt == 7'(SETTLE_HALF_PERIODS - 1)) begin
            nxt_cur.st = ST_LOCKED;
          end
        end
        default: nxt_cur = cur_ff;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ff <= '{st: ST_OFF, cnt: 7'h00};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign tuning_o = (cur_ff.st == ST_TUNE) || (cur_ff.st == ST_OFF && enable_i);
  assign settled_o = (cur_ff.st == ST_LOCKED);

  property p_tune_length;
    @(posedge clk_i) disable iff (rst_i)
      $rose(cur_ff.st == ST_SETTLE) |-> $past(cur_ff.cnt) == 7'(TUNE_HALF_PERIODS - 1);
  endproperty
  a_tune_length: assert property (p_tune_length) else $error("Tune length wrong");

  property p_off_when_disabled;
    @(posedge clk_i) disable iff (rst_i)
      !enable_i |=> cur_ff.st == ST_OFF;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) else $error("Not off");

  property p_settle_length;
    @(posedge clk_i) disable iff (rst_i)
      $rose(settled_o) |-> $past(cur_ff.cnt) == 7'(SETTLE_HALF_PERIODS - 1);
  endproperty
  a_settle_length: assert property (p_settle_length) else $error("Settle length wrong");
endmodule : pll_timing

//--- src/synth_control_register_logic.sv
// Serial register bank and control of a three-PLL synthesizer
//
// Functional notes
// - Reference divided by fixed 65 in every PLL, 200 kHz compare rate.
// - RF output follows whichever RF divide register was written last.
// - RF1 divide from register 3, RF2 from 4, IF from 5.
// - Prescaler, swallow and main counts derived internally from N.
// - Self-tune for 6.5 compare periods after power-up or frequency change.
// - Well settled about 28 periods, 140 us, after the change.
// - Low-bias bit set reduces IF amplifier bias; host picks by load.
// - Power-down pin low forces IF and RF off.
// - Power-down pin high: register bits alone set section power.
// - With auto clear, each enable bit switches its section.
// - Reference amplifier on when pin high and either enable bit or the auto bit is high.
// - Auto bit set acts as both enable bits set.
// - Serial port accepts writes in every power-down state.
// - Aux select 11 puts active-low lock detect on aux pin.
// - Frame is 22 bits: 18 data then 4 address.
// - Data shifted on rising serial clock while enable low.
// - Enable rising edge loads register; earlier leading bits ignored.
// - Lock detect high while any PLL self-tunes or is near its limit, low otherwise.
`timescale 1ns/100ps
module synth_control_register_logic
  import synth_ctrl_pkg::*;
#(
  parameter int REF_DIV = REF_DIVIDE_RATIO,
  parameter int PRESCALE = PRESCALER_P
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_in_i,
  input wire logic serial_enable_n_i,
  input wire logic power_down_pin_n_i,
  input wire logic reference_input_i,
  input wire logic rf1_near_limit_i,
  input wire logic rf2_near_limit_i,
  input wire logic if_near_limit_i,
  output logic rf1_pll_on_o,
  output logic rf2_pll_on_o,
  output logic if_pll_on_o,
  output logic ref_amp_on_o,
  output logic rf_output_select_o,
  output logic if_low_bias_o,
  output logic aux_output_pin_o,
  output logic compare_tick_o,
  output logic [17:0] rf1_divide_o,
  output logic [16:0] rf2_divide_o,
  output logic [15:0] if_divide_o,
  output logic [5:0] active_prescale_ratio_o,
  output logic [12:0] active_main_count_o,
  output logic [5:0] active_swallow_count_o
);
  import synth_ctrl_pkg::*;

  // Refuse settings the counters cannot hold; an 18-bit N needs P of 32 or more
  if (REF_DIV < 2 || REF_DIV > 127) begin : g_bad_ref_div
    $error("REF_DIV out of range");
  end
  if (PRESCALE < 32 || PRESCALE > 63) begin : g_bad_prescale
    $error("PRESCALE out of range");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] sdat_sync;
    logic [2:0] serial_enable_n_sync;
    logic [2:0] xin_sync;
    logic sclk_q;
    logic serial_enable_n_q;
    logic xin_q;
    logic [2:0] pin_sync;
    logic pin_q;
    logic [FRAME_BITS-1:0] shift;
    logic [17:0] main_cfg;
    logic [17:0] pwr_en;
    logic [17:0] rf1_n;
    logic [16:0] rf2_n;
    logic [15:0] if_n;
    logic rf_sel;
    logic rf1_chg;
    logic rf2_chg;
    logic if_chg;
    logic [6:0] ref_cnt;
    logic half_tick;
    logic full_tick;
  } state_s;

  state_s cur_ff, nxt_cur;

  // Stable versions: except data, the second and third stages must agree
  logic sclk_lvl, serial_enable_n_lvl, xin_lvl, sdat_lvl, pin_lvl;
  logic sclk_rise, serial_enable_n_rise, xin_rise;
  logic [ADDR_BITS-1:0] frame_addr;
  logic [DATA_BITS-1:0] frame_data;
  logic if_on, rf_on;
  logic rf1_tuning, rf2_tuning, if_tuning;
  logic rf1_settled, rf2_settled, if_settled;

  // Agreeing pair updates the filtered level, else it holds
  function automatic logic agree(input logic [2:0] s, input logic held);
    agree = (s[1] == s[2]) ? s[2] : held;
  endfunction : agree

  // Split N into main count and swallow count for a P/P+1 prescaler
  function automatic logic [17:0] main_count(input logic [17:0] n);
    main_count = n / 18'(PRESCALE);
  endfunction : main_count

  function automatic logic [17:0] swallow_count(input logic [17:0] n);
    swallow_count = n % 18'(PRESCALE);
  endfunction : swallow_count

  assign sclk_lvl = agree(cur_ff.sclk_sync, cur_ff.sclk_q);
  assign serial_enable_n_lvl = agree(cur_ff.serial_enable_n_sync, cur_ff.serial_enable_n_q);
  assign xin_lvl = agree(cur_ff.xin_sync, cur_ff.xin_q);
  assign pin_lvl = agree(cur_ff.pin_sync, cur_ff.pin_q);
  assign sdat_lvl = cur_ff.sdat_sync[2];
  assign sclk_rise = sclk_lvl && !cur_ff.sclk_q;
  assign serial_enable_n_rise = serial_enable_n_lvl && !cur_ff.serial_enable_n_q;
  assign xin_rise = xin_lvl && !cur_ff.xin_q;
  assign frame_addr = cur_ff.shift[ADDR_BITS-1:0];
  assign frame_data = cur_ff.shift[FRAME_BITS-1:ADDR_BITS];

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Serial port ignores power state entirely, so writes to used addresses always land
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.sclk_sync = {cur_ff.sclk_sync[1:0], serial_clock_i};
    nxt_cur.sdat_sync = {cur_ff.sdat_sync[1:0], serial_data_in_i};
    nxt_cur.serial_enable_n_sync = {cur_ff.serial_enable_n_sync[1:0], serial_enable_n_i};
    nxt_cur.xin_sync = {cur_ff.xin_sync[1:0], reference_input_i};
    nxt_cur.sclk_q = sclk_lvl;
    nxt_cur.serial_enable_n_q = serial_enable_n_lvl;
    nxt_cur.xin_q = xin_lvl;
    nxt_cur.pin_sync = {cur_ff.pin_sync[1:0], power_down_pin_n_i};
    nxt_cur.pin_q = pin_lvl;
    nxt_cur.rf1_chg = 1'b0;
    nxt_cur.rf2_chg = 1'b0;
    nxt_cur.if_chg = 1'b0;
    // Shift on serial clock rise while enabled; only the last 22 survive
    if (!serial_enable_n_lvl && sclk_rise) begin
      nxt_cur.shift = {cur_ff.shift[FRAME_BITS-2:0], sdat_lvl};
    end
    // Enable rising edge loads the addressed register
    if (serial_enable_n_rise) begin
      unique case (frame_addr)
        ADDR_MAIN_CONFIGURATION: nxt_cur.main_cfg = frame_data;
        ADDR_SECTION_POWER_ENABLES: nxt_cur.pwr_en = frame_data;
        ADDR_RF_BAND1_DIVIDE_VALUE: begin
          nxt_cur.rf1_n = frame_data[RF1_N_BITS-1:0];
          nxt_cur.rf_sel = 1'b0;
          nxt_cur.rf1_chg = 1'b1;
        end
        ADDR_RF_BAND2_DIVIDE_VALUE: begin
          nxt_cur.rf2_n = frame_data[RF2_N_BITS-1:0];
          nxt_cur.rf_sel = 1'b1;
          nxt_cur.rf2_chg = 1'b1;
        end
        ADDR_IF_DIVIDE_VALUE: begin
          nxt_cur.if_n = frame_data[IF_N_BITS-1:0];
          nxt_cur.if_chg = 1'b1;
        end
        // Reserved addresses are dropped rather than guessed at
        default: nxt_cur.shift = cur_ff.shift;
      endcase
    end
    // Fixed divide of the reference; ticks at each half and full period
    nxt_cur.half_tick = 1'b0;
    nxt_cur.full_tick = 1'b0;
    if (xin_rise) begin
      if (cur_ff.ref_cnt == 7'(REF_DIV - 1)) begin
        nxt_cur.ref_cnt = 7'h00;
        nxt_cur.half_tick = 1'b1;
        nxt_cur.full_tick = 1'b1;
      end else begin
        nxt_cur.ref_cnt = cur_ff.ref_cnt + 7'h01;
        nxt_cur.half_tick = (cur_ff.ref_cnt == 7'(REF_DIV / 2 - 1));
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ff <= '{
        sclk_sync: 3'h0, sdat_sync: 3'h0, serial_enable_n_sync: 3'h7, xin_sync: 3'h0,
        sclk_q: 1'b0, serial_enable_n_q: 1'b1, xin_q: 1'b0, shift: '0,
        pin_sync: 3'h0, pin_q: 1'b0,
        main_cfg: MAIN_CONFIGURATION_RST, pwr_en: REG_ZERO_RST,
        rf1_n: REG_ZERO_RST, rf2_n: 17'h00000, if_n: 16'h0000,
        rf_sel: 1'b0, rf1_chg: 1'b0, rf2_chg: 1'b0, if_chg: 1'b0,
        ref_cnt: 7'h00, half_tick: 1'b0, full_tick: 1'b0
      };
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************************************
  // Power control
  // ****************************************************************
  // Filtered pin level, so the tune sequencers never see an unsynced edge
  always_comb begin
    if (!pin_lvl) begin
      if_on = 1'b0;
      rf_on = 1'b0;
    end else if (cur_ff.main_cfg[AUTO_POWER_ON_BIT]) begin
      if_on = 1'b1;
      rf_on = 1'b1;
    end else begin
      if_on = cur_ff.pwr_en[IF_ENABLE_BIT];
      rf_on = cur_ff.pwr_en[RF_ENABLE_BIT];
    end
  end

  assign if_pll_on_o = if_on;
  assign rf1_pll_on_o = rf_on && !cur_ff.rf_sel;
  assign rf2_pll_on_o = rf_on && cur_ff.rf_sel;
  assign ref_amp_on_o = pin_lvl && (cur_ff.pwr_en[IF_ENABLE_BIT] ||
                        cur_ff.pwr_en[RF_ENABLE_BIT] ||
                        cur_ff.main_cfg[AUTO_POWER_ON_BIT]);
  assign rf_output_select_o = cur_ff.rf_sel;
  assign if_low_bias_o = cur_ff.main_cfg[IF_LOW_BIAS_BIT];
  assign compare_tick_o = cur_ff.full_tick;
  assign rf1_divide_o = cur_ff.rf1_n;
  assign rf2_divide_o = cur_ff.rf2_n;
  assign if_divide_o = cur_ff.if_n;

  // Counter split of the active RF divider
  always_comb begin
    logic [17:0] n;
    n = cur_ff.rf_sel ? {1'b0, cur_ff.rf2_n} : cur_ff.rf1_n;
    active_prescale_ratio_o = 6'(PRESCALE);
    active_main_count_o = 13'(main_count(n));
    active_swallow_count_o = 6'(swallow_count(n));
  end

  // ****************************************************************
  // Self-tune sequencers
  // ****************************************************************
  pll_timing u_rf1 (
    .clk_i(clk_i), .rst_i(rst_i), .half_tick_i(cur_ff.half_tick),
    .enable_i(rf1_pll_on_o), .retune_i(cur_ff.rf1_chg),
    .tuning_o(rf1_tuning), .settled_o(rf1_settled)
  );
  pll_timing u_rf2 (
    .clk_i(clk_i), .rst_i(rst_i), .half_tick_i(cur_ff.half_tick),
    .enable_i(rf2_pll_on_o), .retune_i(cur_ff.rf2_chg),
    .tuning_o(rf2_tuning), .settled_o(rf2_settled)
  );
  pll_timing u_if (
    .clk_i(clk_i), .rst_i(rst_i), .half_tick_i(cur_ff.half_tick),
    .enable_i(if_on), .retune_i(cur_ff.if_chg),
    .tuning_o(if_tuning), .settled_o(if_settled)
  );

  // Aux pin: lock detect or forced low; reserved codes also drive low
  always_comb begin
    logic lock_n;
    lock_n = rf1_tuning || rf2_tuning || if_tuning ||
             rf1_near_limit_i || rf2_near_limit_i || if_near_limit_i;
    if (cur_ff.main_cfg[AUX_SEL_LSB+1:AUX_SEL_LSB] == AUX_SEL_LOCK) begin
      aux_output_pin_o = lock_n;
    end else begin
      aux_output_pin_o = 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pin_forces_off;
    @(posedge clk_i) disable iff (rst_i)
      !pin_lvl |-> !if_pll_on_o && !rf1_pll_on_o && !rf2_pll_on_o;
  endproperty
  a_pin_forces_off: assert property (p_pin_forces_off) else $error("Pin off ignored");

  property p_auto_on;
    @(posedge clk_i) disable iff (rst_i)
      pin_lvl && cur_ff.main_cfg[AUTO_POWER_ON_BIT] |-> if_pll_on_o;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("Auto power failed");

  property p_rf2_select;
    @(posedge clk_i) disable iff (rst_i)
      serial_enable_n_rise && frame_addr == ADDR_RF_BAND2_DIVIDE_VALUE |=> rf_output_select_o;
  endproperty
  a_rf2_select: assert property (p_rf2_select) else $error("RF2 not selected");

  property p_rf1_select;
    @(posedge clk_i) disable iff (rst_i)
      serial_enable_n_rise && frame_addr == ADDR_RF_BAND1_DIVIDE_VALUE |=> !rf_output_select_o;
  endproperty
  a_rf1_select: assert property (p_rf1_select) else $error("RF1 not selected");

  property p_if_load;
    @(posedge clk_i) disable iff (rst_i)
      serial_enable_n_rise && frame_addr == ADDR_IF_DIVIDE_VALUE
      |=> if_divide_o == $past(frame_data[IF_N_BITS-1:0]);
  endproperty
  a_if_load: assert property (p_if_load) else $error("IF divide not loaded");

  property p_ref_period;
    @(posedge clk_i) disable iff (rst_i)
      xin_rise && cur_ff.ref_cnt == 7'(REF_DIV - 1) |=> compare_tick_o;
  endproperty
  a_ref_period: assert property (p_ref_period) else $error("Reference divide wrong");

  property p_lock_aux;
    @(posedge clk_i) disable iff (rst_i)
      cur_ff.main_cfg[13:12] == AUX_SEL_LOCK && if_tuning |-> aux_output_pin_o;
  endproperty
  a_lock_aux: assert property (p_lock_aux) else $error("Lock detect low in tune");

  property p_shift_hold;
    @(posedge clk_i) disable iff (rst_i)
      serial_enable_n_lvl && !serial_enable_n_rise |=> $stable(cur_ff.shift);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("Shift while disabled");

  property p_ref_amp;
    @(posedge clk_i) disable iff (rst_i)
      pin_lvl && cur_ff.pwr_en[RF_ENABLE_BIT] |-> ref_amp_on_o;
  endproperty
  a_ref_amp: assert property (p_ref_amp) else $error("Reference amp off");

  // A PLL is never tuning and settled at once
  property p_tune_settle_excl;
    @(posedge clk_i) disable iff (rst_i)
      !(rf1_tuning && rf1_settled) && !(rf2_tuning && rf2_settled) &&
      !(if_tuning && if_settled);
  endproperty
  a_tune_settle_excl: assert property (p_tune_settle_excl) else $error("Tune and settle");
endmodule : synth_control_register_logic

//--- tb/serial_host_model.sv
// Baseband host model driving the three-wire serial programming port
`timescale 1ns/100ps
module serial_host_model
  import synth_ctrl_pkg::*;
(
  input wire logic clk_i,
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic serial_enable_n_o
);
  import synth_ctrl_pkg::*;

  // ****************************************
  // Idle state
  // ****************************************
  // Clock stands still low and the port is deselected between frames
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
    serial_enable_n_o = 1'b1;
  end

  // ****************************************
  // Frame transfer
  // ****************************************
  // Data moves mid low phase so it is steady well around each rising edge
  task automatic send_frame(input logic [3:0] addr, input logic [17:0] data, input int lead);
    logic [21:0] word;
    logic bit_v;
    word = {data, addr};
    @(posedge clk_i);
    serial_enable_n_o <= 1'b0;
    for (int i = lead + FRAME_BITS - 1; i >= 0; i--) begin
      repeat (2) @(posedge clk_i);
      bit_v = (i < FRAME_BITS) ? word[i] : 1'($urandom);
      serial_data_o <= bit_v;
      repeat (2) @(posedge clk_i);
      serial_clock_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      serial_clock_o <= 1'b0;
    end
    // Last rise must be seen before the port is closed
    repeat (4) @(posedge clk_i);
    serial_enable_n_o <= 1'b1;
    serial_data_o <= ~serial_data_o;
    repeat (4) @(posedge clk_i);
  endtask : send_frame
endmodule : serial_host_model

//--- tb/test_synth_control_register_logic.sv
// Self-checking bench for the synthesizer register bank and control logic
`timescale 1ns/100ps
module test_synth_control_register_logic;
  import synth_ctrl_pkg::*;

  typedef struct packed {
    logic rf1, rf2, ifo, refa, sel, lb, aux;
    logic [17:0] d1;
    logic [16:0] d2;
    logic [15:0] di;
    logic [12:0] mc;
    logic [5:0] sw;
  } note_s;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_n = 1'b1;
  logic ref_in = 1'b0;
  logic [2:0] near = 3'h0;
  logic sclk, serial_data_in, sen_n, rf1_on, rf2_on, if_on, ref_on, rf_sel, low_bias, aux, tick;
  logic [17:0] d1;
  logic [16:0] d2;
  logic [15:0] di;
  logic [5:0] pr;
  logic [12:0] mc;
  logic [5:0] sw;
  logic [17:0] sh_main = MAIN_CONFIGURATION_RST;
  logic [17:0] sh_pwr = REG_ZERO_RST;
  logic [17:0] sh_n1 = REG_ZERO_RST;
  logic [17:0] sh_n2 = REG_ZERO_RST;
  logic [17:0] sh_nif = REG_ZERO_RST;
  logic sh_sel = 1'b0;
  logic chk = 1'b0;
  note_s notes[$];
  note_s cur;
  int fail_count = 0;
  int compares = 0;
  int cnt;

  // ****************************************
  // Clocks and instances
  // ****************************************
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Reference runs free at 800 ns, offset so its edges avoid the system edges
  initial begin
    #37;
    forever #400 ref_in = ~ref_in;
  end

  serial_host_model serial_host_model_i (.clk_i(clk_i), .serial_clock_o(sclk),
    .serial_data_o(serial_data_in), .serial_enable_n_o(sen_n));

  synth_control_register_logic synth_control_register_logic_i (.clk_i(clk_i),
    .rst_i(rst_i), .serial_clock_i(sclk), .serial_data_in_i(serial_data_in),
    .serial_enable_n_i(sen_n), .power_down_pin_n_i(pin_n), .reference_input_i(ref_in),
    .rf1_near_limit_i(near[0]), .rf2_near_limit_i(near[1]), .if_near_limit_i(near[2]),
    .rf1_pll_on_o(rf1_on), .rf2_pll_on_o(rf2_on), .if_pll_on_o(if_on),
    .ref_amp_on_o(ref_on), .rf_output_select_o(rf_sel), .if_low_bias_o(low_bias),
    .aux_output_pin_o(aux), .compare_tick_o(tick), .rf1_divide_o(d1), .rf2_divide_o(d2),
    .if_divide_o(di), .active_prescale_ratio_o(pr), .active_main_count_o(mc),
    .active_swallow_count_o(sw));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [17:0] mk_main(input logic [1:0] s, input logic lb, input logic au);
    return {4'h0, s, 6'h00, lb, 1'b0, au, 3'h2};
  endfunction : mk_main

  // Expected outputs from the shadow registers and the power-down pin
  function automatic note_s predict(input logic aux_exp);
    note_s n;
    logic rf_en;
    logic if_en;
    logic [17:0] nsel;
    rf_en = pin_n & (sh_main[AUTO_POWER_ON_BIT] | sh_pwr[RF_ENABLE_BIT]);
    if_en = pin_n & (sh_main[AUTO_POWER_ON_BIT] | sh_pwr[IF_ENABLE_BIT]);
    nsel = sh_sel ? {1'b0, sh_n2[16:0]} : sh_n1;
    n.rf1 = rf_en & ~sh_sel;
    n.rf2 = rf_en & sh_sel;
    n.ifo = if_en;
    n.refa = rf_en | if_en;
    n.sel = sh_sel;
    n.lb = sh_main[IF_LOW_BIAS_BIT];
    n.aux = aux_exp;
    n.d1 = sh_n1;
    n.d2 = sh_n2[16:0];
    n.di = sh_nif[15:0];
    n.mc = 13'(nsel / PRESCALER_P);
    n.sw = 6'(nsel % PRESCALER_P);
    return n;
  endfunction : predict

  // Only documented addresses are ever written, never 1 or 6 to 15
  task automatic write_reg(input logic [3:0] addr, input logic [17:0] data, input int lead);
    serial_host_model_i.send_frame(addr, data, lead);
    case (addr)
      ADDR_MAIN_CONFIGURATION: sh_main = data;
      ADDR_SECTION_POWER_ENABLES: sh_pwr = data;
      ADDR_RF_BAND1_DIVIDE_VALUE: begin
        sh_n1 = data;
        sh_sel = 1'b0;
      end
      ADDR_RF_BAND2_DIVIDE_VALUE: begin
        sh_n2 = data;
        sh_sel = 1'b1;
      end
      ADDR_IF_DIVIDE_VALUE: sh_nif = data;
      default: ;
    endcase
  endtask : write_reg

  // Note the expectation, then let the load settle before the monitor looks
  task automatic expect_now(input logic aux_exp);
    notes.push_back(predict(aux_exp));
    repeat (8) @(posedge clk_i);
    chk <= 1'b1;
    @(posedge clk_i);
    chk <= 1'b0;
  endtask : expect_now

  // ****************************************
  // Output monitor
  // ****************************************
  always @(posedge clk_i) begin
    if (chk && notes.size() > 0) begin
      cur = notes.pop_front();
      check("rf1_on", 32'(rf1_on), 32'(cur.rf1));
      check("rf2_on", 32'(rf2_on), 32'(cur.rf2));
      check("if_on", 32'(if_on), 32'(cur.ifo));
      check("ref_on", 32'(ref_on), 32'(cur.refa));
      check("rf_sel", 32'(rf_sel), 32'(cur.sel));
      check("low_bias", 32'(low_bias), 32'(cur.lb));
      check("aux", 32'(aux), 32'(cur.aux));
      check("rf1_div", 32'(d1), 32'(cur.d1));
      check("rf2_div", 32'(d2), 32'(cur.d2));
      check("if_div", 32'(di), 32'(cur.di));
      check("main_count", 32'(mc), 32'(cur.mc));
      check("swallow", 32'(sw), 32'(cur.sw));
      check("prescale", 32'(pr), 32'(PRESCALER_P));
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h0CF1));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    expect_now(1'b0);
    // Every used register written, outputs checked after reset and between writes
    write_reg(ADDR_MAIN_CONFIGURATION, mk_main(AUX_SEL_LOW, 1'b1, 1'b0), 0);
    expect_now(1'b0);
    write_reg(ADDR_SECTION_POWER_ENABLES, 18'h00003, 0);
    write_reg(ADDR_IF_DIVIDE_VALUE, {2'h0, 16'($urandom)}, 0);
    write_reg(ADDR_RF_BAND2_DIVIDE_VALUE, {1'b0, 17'($urandom)}, 0);
    expect_now(1'b0);
    write_reg(ADDR_RF_BAND1_DIVIDE_VALUE, 18'($urandom), 0);
    expect_now(1'b0);
    // Leading junk bits ahead of the frame must fall out of the shifter
    write_reg(ADDR_RF_BAND2_DIVIDE_VALUE, {1'b0, 17'($urandom)}, 5);
    expect_now(1'b0);
    // Whole power table; pin set first so half the writes land while forced off
    for (int k = 0; k < 16; k++) begin
      pin_n <= k[3];
      write_reg(ADDR_MAIN_CONFIGURATION, mk_main(AUX_SEL_LOW, k[0], k[2]), 0);
      write_reg(ADDR_SECTION_POWER_ENABLES, {16'h0000, 2'(k)}, 0);
      expect_now(1'b0);
    end
    pin_n <= 1'b0;
    write_reg(ADDR_MAIN_CONFIGURATION, mk_main(AUX_SEL_LOW, 1'b0, 1'b0), 0);
    write_reg(ADDR_SECTION_POWER_ENABLES, 18'h00002, 0);
    pin_n <= 1'b1;
    @(posedge clk_i);
    expect_now(1'b0);
    // Compare tick spacing: 65 reference rises of 8 system clocks each
    cnt = 0;
    while (tick !== 1'b1 && cnt < 2000) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= 2000) begin
      check("tick_wait", 32'(cnt), 32'h0);
    end
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (tick !== 1'b1 && cnt < 2000);
    check("tick_spacing", 32'(cnt), 32'(REF_DIVIDE_RATIO * 8));
    // Lock detect: high through self-tune after a new N, low after, high near limit
    write_reg(ADDR_MAIN_CONFIGURATION, mk_main(AUX_SEL_LOCK, 1'b0, 1'b1), 0);
    write_reg(ADDR_RF_BAND1_DIVIDE_VALUE, 18'($urandom), 0);
    expect_now(1'b1);
    repeat (2900) @(posedge clk_i);
    expect_now(1'b1);
    repeat (1200) @(posedge clk_i);
    expect_now(1'b0);
    for (int j = 0; j < 3; j++) begin
      near <= 3'(1 << j);
      expect_now(1'b1);
      near <= 3'h0;
      expect_now(1'b0);
    end
    give_verdict();
  end
endmodule : test_synth_control_register_logic
